// file: core/dpas_pkg.sv
// Purpose: Shared constants and types for the host-side controller of one
//          port of an asynchronous dual-port RAM with semaphores and collision flag.
// Assumes: One 20 MHz clock; the memory port is reached only through its pins.
// Notes:   Pin timing is held as times in ns with cycle counts derived from them.
package dpas_pkg;

    localparam int unsigned DATA_W          = 16;
    localparam int unsigned ADDR_W          = 13;
    localparam int unsigned SEM_IDX_W       = 3;
    localparam int unsigned COUNT_W         = 8;

    localparam int unsigned CLK_PERIOD_NS   = 50;
    // Slowest grade figures, so any grade works from the same counts
    localparam int unsigned READ_ACCESS_NS  = 55;
    localparam int unsigned WRITE_PULSE_NS  = 50;
    localparam int unsigned WRITE_TO_HIZ_NS = 25;
    localparam int unsigned SEM_W2R_NS      = 15;
    localparam int unsigned SEM_PULSE_NS    = 20;

    function automatic int unsigned ceil_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ceil_cycles

    localparam logic [COUNT_W-1:0] READ_ACCESS_CYCLES = COUNT_W'(ceil_cycles(READ_ACCESS_NS));
    localparam logic [COUNT_W-1:0] WRITE_PULSE_CYCLES = COUNT_W'(ceil_cycles(WRITE_PULSE_NS));
    localparam logic [COUNT_W-1:0] TURN_CYCLES        = COUNT_W'(ceil_cycles(WRITE_TO_HIZ_NS));
    localparam logic [COUNT_W-1:0] SEM_GAP_CYCLES     = COUNT_W'(ceil_cycles(SEM_W2R_NS + SEM_PULSE_NS));
    localparam logic [COUNT_W-1:0] HOLD_CYCLES        = 8'h01;
    // A one-cycle busy pulse never passes the agreement filter, so array writes strobe at least this long
    localparam logic [COUNT_W-1:0] FLAG_MIN_CYCLES    = 8'h02;
    localparam logic [COUNT_W-1:0] WR_STROBE_CYCLES   = (WRITE_PULSE_CYCLES > FLAG_MIN_CYCLES) ?
                                                        WRITE_PULSE_CYCLES : FLAG_MIN_CYCLES;
    // Three-stage synchroniser plus filtered output register
    localparam logic [COUNT_W-1:0] SYNC_SETTLE_CYCLES = 8'h05;

    typedef enum logic [2:0] {
        OP_RAM_READ  = 3'h0,
        OP_RAM_WRITE = 3'h1,
        OP_SEM_TAKE  = 3'h2,
        OP_SEM_GIVE  = 3'h3,
        OP_SEM_READ  = 3'h4
    } dpas_op_t;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_SETUP     = 4'h1,
        ST_RD_ACCESS = 4'h2,
        ST_WR_PULSE  = 4'h3,
        ST_WR_HOLD   = 4'h4,
        ST_WR_CHECK  = 4'h5,
        ST_SEM_WRITE = 4'h6,
        ST_SEM_HOLD  = 4'h7,
        ST_SEM_GAP   = 4'h8,
        ST_SEM_READ  = 4'h9,
        ST_DONE      = 4'hA
    } dpas_fsm_t;

    typedef struct packed {
        dpas_op_t              op;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
        logic                  upper_en;
        logic                  lower_en;
    } dpas_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0]     rdata;
        logic                  granted;
        logic                  collided;
    } dpas_rsp_t;

    typedef struct packed {
        logic                  chip_select_n;
        logic                  semaphore_select_n;
        logic                  read_write_n;
        logic                  output_enable_n;
        logic                  upper_byte_enable_n;
        logic                  lower_byte_enable_n;
    } dpas_pin_ctrl_t;

    localparam dpas_pin_ctrl_t PINS_IDLE = 6'h3F;

endpackage : dpas_pkg

// file: core/dpas_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to clk.
// Notes:   Output follows only when stages two and three agree.
`timescale 1ns/1ps
module dpas_sync #(
    parameter int unsigned   W         = 1,
    parameter logic [W-1:0]  RESET_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dpas_sync_state_t;

    dpas_sync_state_t s;
    dpas_sync_state_t next_s;

    always_comb
    begin
        next_s    = s;
        next_s.s1 = d;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        if (s.s2 == s.s3)
        begin
            next_s.q = s.s3;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign q = s.q;
endmodule : dpas_sync

// file: core/dpas_port_ctrl.sv
// Purpose: Host controller that drives one port of an asynchronous dual-port RAM:
//          array reads and writes, semaphore take, give and read-back.
// Assumes: 20 MHz REF_CLK; pin inputs are asynchronous and are synchronised here.
// Notes:   One command at a time; a flagged collision is retried up to RETRY_LIMIT.
`timescale 1ns/1ps
module dpas_port_ctrl #(
    parameter logic [1:0] RETRY_LIMIT = 2'h3
) (
    input  wire logic                          REF_CLK,
    input  wire logic                          ARST_N,
    input  wire logic                          CMD_VALID,
    input  wire dpas_pkg::dpas_cmd_t           CMD,
    output logic                               CMD_READY,
    output logic                               RSP_VALID,
    output dpas_pkg::dpas_rsp_t                RSP,
    output dpas_pkg::dpas_pin_ctrl_t           PIN_CTRL,
    output logic [dpas_pkg::ADDR_W-1:0]        PIN_ADDR,
    output logic [dpas_pkg::DATA_W-1:0]        PIN_DATA_OUT,
    output logic                               PIN_DATA_OE,
    input  wire logic [dpas_pkg::DATA_W-1:0]   PIN_DATA_IN,
    input  wire logic                          PIN_COLLISION_FLAG_N
);
    typedef enum logic [1:0] {
        ACC_NONE = 2'h0,
        ACC_RAM  = 2'h1,
        ACC_SEM  = 2'h2
    } dpas_acc_t;

    typedef struct packed {
        dpas_pkg::dpas_fsm_t                 fsm;
        logic [dpas_pkg::COUNT_W-1:0]        count;
        logic [1:0]                          retries;
        dpas_pkg::dpas_cmd_t                 cmd;
        logic                                collided;
        dpas_pkg::dpas_pin_ctrl_t            pins;
        logic [dpas_pkg::ADDR_W-1:0]         addr;
        logic [dpas_pkg::DATA_W-1:0]         dout;
        logic                                doe;
        logic                                cmd_ready;
        logic                                rsp_valid;
        dpas_pkg::dpas_rsp_t                 rsp;
    } dpas_ctrl_state_t;

    dpas_ctrl_state_t              s;
    dpas_ctrl_state_t              next_s;
    logic                          collision_n;
    logic [dpas_pkg::DATA_W-1:0]   data_in;

    dpas_sync #(.W(1), .RESET_VAL(1'h1)) u_sync_collision (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .d      (PIN_COLLISION_FLAG_N),
        .q      (collision_n)
    );

    dpas_sync #(.W(dpas_pkg::DATA_W), .RESET_VAL(16'h0000)) u_sync_data (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .d      (PIN_DATA_IN),
        .q      (data_in)
    );

    // Select decoding for both kinds of access; write strobe and the active select move together
    function automatic dpas_pkg::dpas_pin_ctrl_t pins_for(input dpas_acc_t acc, input logic wr,
                                                          input dpas_pkg::dpas_cmd_t c);
        dpas_pkg::dpas_pin_ctrl_t p;
        p = dpas_pkg::PINS_IDLE;
        case (acc)
            ACC_RAM:
            begin
                p.chip_select_n       = 1'h0;
                p.semaphore_select_n  = 1'h1;
                p.upper_byte_enable_n = ~c.upper_en;
                p.lower_byte_enable_n = ~c.lower_en;
                p.read_write_n        = ~wr;
                p.output_enable_n     = wr;
            end
            ACC_SEM:
            begin
                p.chip_select_n       = 1'h1;
                p.semaphore_select_n  = 1'h0;
                p.read_write_n        = ~wr;
                p.output_enable_n     = wr;
            end
            default:
            begin
                p = dpas_pkg::PINS_IDLE;
            end
        endcase
        return p;
    endfunction : pins_for

    // Decide between a retry and the answer at the end of an array access
    function automatic logic want_retry(input logic collided, input logic [1:0] retries);
        return collided && (retries < RETRY_LIMIT);
    endfunction : want_retry

    always_comb
    begin
        next_s           = s;
        next_s.rsp_valid = 1'h0;
        if (s.count != 8'h00)
        begin
            next_s.count = s.count - 8'h01;
        end
        case (s.fsm)
            dpas_pkg::ST_IDLE:
            begin
                next_s.pins = dpas_pkg::PINS_IDLE;
                next_s.doe  = 1'h0;
                if (CMD_VALID && s.cmd_ready)
                begin
                    next_s.cmd       = CMD;
                    next_s.cmd_ready = 1'h0;
                    next_s.retries   = 2'h0;
                    next_s.collided  = 1'h0;
                    // An array access with no byte lane would select nothing
                    if (!CMD.upper_en && !CMD.lower_en)
                    begin
                        next_s.cmd.upper_en = 1'h1;
                        next_s.cmd.lower_en = 1'h1;
                    end
                    if (CMD.op == dpas_pkg::OP_RAM_READ || CMD.op == dpas_pkg::OP_RAM_WRITE)
                    begin
                        next_s.addr = CMD.addr;
                    end
                    else
                    begin
                        next_s.addr = {{(dpas_pkg::ADDR_W-dpas_pkg::SEM_IDX_W){1'h0}},
                                       CMD.addr[dpas_pkg::SEM_IDX_W-1:0]};
                    end
                    next_s.dout  = CMD.wdata;
                    next_s.fsm   = dpas_pkg::ST_SETUP;
                    next_s.count = dpas_pkg::TURN_CYCLES;
                end
            end
            dpas_pkg::ST_SETUP:
            begin
                // Deselected with outputs off; data bus left floating for the turnaround
                if (s.count <= 8'h01)
                begin
                    next_s.collided = 1'h0;
                    case (s.cmd.op)
                        dpas_pkg::OP_RAM_READ:
                        begin
                            next_s.pins  = pins_for(ACC_RAM, 1'h0, s.cmd);
                            next_s.fsm   = dpas_pkg::ST_RD_ACCESS;
                            next_s.count = dpas_pkg::READ_ACCESS_CYCLES + dpas_pkg::SYNC_SETTLE_CYCLES;
                        end
                        dpas_pkg::OP_RAM_WRITE:
                        begin
                            next_s.pins  = pins_for(ACC_RAM, 1'h1, s.cmd);
                            next_s.doe   = 1'h1;
                            next_s.fsm   = dpas_pkg::ST_WR_PULSE;
                            next_s.count = dpas_pkg::WR_STROBE_CYCLES;
                        end
                        dpas_pkg::OP_SEM_TAKE,
                        dpas_pkg::OP_SEM_GIVE:
                        begin
                            next_s.pins    = pins_for(ACC_SEM, 1'h1, s.cmd);
                            next_s.dout    = '0;
                            next_s.dout[0] = (s.cmd.op == dpas_pkg::OP_SEM_GIVE);
                            next_s.doe     = 1'h1;
                            next_s.fsm     = dpas_pkg::ST_SEM_WRITE;
                            next_s.count   = dpas_pkg::WRITE_PULSE_CYCLES;
                        end
                        dpas_pkg::OP_SEM_READ:
                        begin
                            next_s.pins  = pins_for(ACC_SEM, 1'h0, s.cmd);
                            next_s.fsm   = dpas_pkg::ST_SEM_READ;
                            next_s.count = dpas_pkg::READ_ACCESS_CYCLES + dpas_pkg::SYNC_SETTLE_CYCLES;
                        end
                        default:
                        begin
                            next_s.fsm = dpas_pkg::ST_DONE;
                        end
                    endcase
                end
            end
            dpas_pkg::ST_RD_ACCESS:
            begin
                if (!collision_n)
                begin
                    next_s.collided = 1'h1;
                end
                if (s.count <= 8'h01)
                begin
                    next_s.pins      = dpas_pkg::PINS_IDLE;
                    next_s.rsp.rdata = data_in;
                    next_s.collided  = s.collided || !collision_n;
                    if (want_retry(s.collided || !collision_n, s.retries))
                    begin
                        next_s.retries = s.retries + 2'h1;
                        next_s.fsm     = dpas_pkg::ST_SETUP;
                        next_s.count   = dpas_pkg::TURN_CYCLES + dpas_pkg::SYNC_SETTLE_CYCLES;
                    end
                    else
                    begin
                        next_s.fsm = dpas_pkg::ST_DONE;
                    end
                end
            end
            dpas_pkg::ST_WR_PULSE:
            begin
                if (!collision_n)
                begin
                    next_s.collided = 1'h1;
                end
                if (s.count <= 8'h01)
                begin
                    // Strobes rise together; data is held one more cycle
                    next_s.pins  = dpas_pkg::PINS_IDLE;
                    next_s.fsm   = dpas_pkg::ST_WR_HOLD;
                    next_s.count = dpas_pkg::HOLD_CYCLES;
                end
            end
            dpas_pkg::ST_WR_HOLD:
            begin
                next_s.doe   = 1'h0;
                next_s.fsm   = dpas_pkg::ST_WR_CHECK;
                next_s.count = dpas_pkg::SYNC_SETTLE_CYCLES;
            end
            dpas_pkg::ST_WR_CHECK:
            begin
                // Flag reaches us late through the synchroniser, so keep looking a while
                if (!collision_n)
                begin
                    next_s.collided = 1'h1;
                end
                if (s.count <= 8'h01)
                begin
                    if (want_retry(s.collided || !collision_n, s.retries))
                    begin
                        next_s.retries = s.retries + 2'h1;
                        next_s.fsm     = dpas_pkg::ST_SETUP;
                        next_s.count   = dpas_pkg::TURN_CYCLES;
                    end
                    else
                    begin
                        next_s.collided = s.collided || !collision_n;
                        next_s.fsm      = dpas_pkg::ST_DONE;
                    end
                end
            end
            dpas_pkg::ST_SEM_WRITE:
            begin
                if (s.count <= 8'h01)
                begin
                    next_s.pins  = dpas_pkg::PINS_IDLE;
                    next_s.fsm   = dpas_pkg::ST_SEM_HOLD;
                    next_s.count = dpas_pkg::HOLD_CYCLES;
                end
            end
            dpas_pkg::ST_SEM_HOLD:
            begin
                next_s.doe   = 1'h0;
                next_s.fsm   = dpas_pkg::ST_SEM_GAP;
                next_s.count = dpas_pkg::SEM_GAP_CYCLES;
            end
            dpas_pkg::ST_SEM_GAP:
            begin
                if (s.count <= 8'h01)
                begin
                    next_s.pins  = pins_for(ACC_SEM, 1'h0, s.cmd);
                    next_s.fsm   = dpas_pkg::ST_SEM_READ;
                    next_s.count = dpas_pkg::READ_ACCESS_CYCLES + dpas_pkg::SYNC_SETTLE_CYCLES;
                end
            end
            dpas_pkg::ST_SEM_READ:
            begin
                if (s.count <= 8'h01)
                begin
                    next_s.pins        = dpas_pkg::PINS_IDLE;
                    next_s.rsp.rdata   = data_in;
                    // Low bit 0 on read-back means this port holds the token
                    next_s.rsp.granted = ~data_in[0];
                    next_s.fsm         = dpas_pkg::ST_DONE;
                end
            end
            dpas_pkg::ST_DONE:
            begin
                next_s.rsp.collided = s.collided;
                if (s.cmd.op == dpas_pkg::OP_RAM_READ || s.cmd.op == dpas_pkg::OP_RAM_WRITE)
                begin
                    next_s.rsp.granted = 1'h0;
                end
                if (s.cmd.op == dpas_pkg::OP_RAM_WRITE)
                begin
                    next_s.rsp.rdata = '0;
                end
                next_s.rsp_valid = 1'h1;
                next_s.cmd_ready = 1'h1;
                next_s.fsm       = dpas_pkg::ST_IDLE;
            end
            default:
            begin
                next_s.pins = dpas_pkg::PINS_IDLE;
                next_s.doe  = 1'h0;
                next_s.fsm  = dpas_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s           <= '0;
            s.fsm       <= dpas_pkg::ST_IDLE;
            s.pins      <= dpas_pkg::PINS_IDLE;
            s.cmd_ready <= 1'h1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign CMD_READY    = s.cmd_ready;
    assign RSP_VALID    = s.rsp_valid;
    assign RSP          = s.rsp;
    assign PIN_CTRL     = s.pins;
    assign PIN_ADDR     = s.addr;
    assign PIN_DATA_OUT = s.dout;
    assign PIN_DATA_OE  = s.doe;
endmodule : dpas_port_ctrl

// file: testbench/dpas_mem_model.sv
// Purpose: Behavioural model of one memory port with array, semaphore latches and collision flag.
// Assumes: The other port is played by the bench through other_sem_req, other_busy and other_addr.
// Notes:   Only 16 words are kept; released data lines show the inverse of the last value.
`timescale 1ns/1ps
module dpas_mem_model (
    input  wire dpas_pkg::dpas_pin_ctrl_t         pins,
    input  wire logic [dpas_pkg::ADDR_W-1:0]      addr,
    input  wire logic [dpas_pkg::DATA_W-1:0]      host_data,
    input  wire logic                             host_oe,
    input  wire logic [7:0]                       other_sem_req,
    input  wire logic                             other_busy,
    input  wire logic [dpas_pkg::ADDR_W-1:0]      other_addr,
    output logic      [dpas_pkg::DATA_W-1:0]      data_pins,
    output logic                                  collision_flag_n
);
    logic [15:0] mem [0:15];
    logic [7:0]  ours = 8'h00;
    logic [7:0]  theirs;
    logic [15:0] rd_val;
    logic [15:0] last = 16'h0000;
    logic [15:0] d_q;
    logic [3:0]  a_q;
    logic        ub_q;
    logic        lb_q;
    logic        ram_q;
    wire ram_sel = !pins.chip_select_n && pins.semaphore_select_n
                   && (!pins.upper_byte_enable_n || !pins.lower_byte_enable_n);
    wire sem_sel = pins.chip_select_n && !pins.semaphore_select_n;
    wire wr_act  = !pins.read_write_n && (ram_sel || sem_sel);
    // No output while the write strobe is low, whichever edge came first
    wire drv     = !pins.output_enable_n && pins.read_write_n && (ram_sel || sem_sel);
    // The other port only gets a latch that this port does not hold
    assign theirs = other_sem_req & ~ours;
    always @*
        if (wr_act)
        begin
            a_q   = addr[3:0];
            ub_q  = pins.upper_byte_enable_n;
            lb_q  = pins.lower_byte_enable_n;
            ram_q = ram_sel;
            d_q   = data_pins;
        end
    // Writes land at the end of the strobe, as the real cell does
    always @(negedge wr_act)
        if (ram_q)
        begin
            if (!ub_q) mem[a_q][15:8] = d_q[15:8];
            if (!lb_q) mem[a_q][7:0] = d_q[7:0];
        end
        else
            ours[a_q[2:0]] = !d_q[0] ? (ours[a_q[2:0]] | ~theirs[a_q[2:0]]) : 1'b0;
    assign rd_val = sem_sel ? {16{~ours[addr[2:0]]}} : mem[addr[3:0]];
    always @*
        if (drv) last = rd_val;
    assign data_pins = host_oe ? host_data : (drv ? rd_val : ~last);
    // This port is flagged whenever it selects the array at the location the other holds, whichever came first
    assign collision_flag_n = !(other_busy && !pins.chip_select_n && addr == other_addr);
endmodule : dpas_mem_model

// file: testbench/dpas_port_ctrl_asserts.sv
// Purpose: Pin-level protocol checks on the port controller.
// Assumes: Bound to dpas_port_ctrl; one clock domain.
// Notes:   Retry bound covers the longest answer with three collisions.
`timescale 1ns/1ps
module dpas_port_ctrl_asserts (
    input wire logic                        REF_CLK,
    input wire logic                        ARST_N,
    input wire logic                        CMD_VALID,
    input wire logic                        CMD_READY,
    input wire logic                        RSP_VALID,
    input wire dpas_pkg::dpas_pin_ctrl_t    PIN_CTRL,
    input wire logic [dpas_pkg::ADDR_W-1:0] PIN_ADDR,
    input wire logic                        PIN_DATA_OE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    read_strobe_high_a: assert property (!PIN_CTRL.output_enable_n |-> PIN_CTRL.read_write_n)
        else $error("write strobe low during read");
    select_exclusive_a: assert property (PIN_CTRL.chip_select_n || PIN_CTRL.semaphore_select_n)
        else $error("array and semaphore selected together");
    ram_byte_en_a: assert property (!PIN_CTRL.chip_select_n |->
        (!PIN_CTRL.upper_byte_enable_n || !PIN_CTRL.lower_byte_enable_n))
        else $error("array select without byte enable");
    addr_before_sel_a: assert property (($fell(PIN_CTRL.chip_select_n) || $fell(PIN_CTRL.semaphore_select_n))
        |-> $stable(PIN_ADDR))
        else $error("address changed at select");
    select_with_strobe_a: assert property ($fell(PIN_CTRL.read_write_n) |->
        ($fell(PIN_CTRL.chip_select_n) || $fell(PIN_CTRL.semaphore_select_n)))
        else $error("select before write strobe");
    drive_turnaround_a: assert property (PIN_DATA_OE |->
        (PIN_CTRL.output_enable_n && $past(PIN_CTRL.output_enable_n)))
        else $error("data driven while memory outputs on");
    sem_request_a: assert property ((!PIN_CTRL.semaphore_select_n && !PIN_CTRL.read_write_n)
        |-> (PIN_CTRL.chip_select_n && PIN_DATA_OE))
        else $error("semaphore write without data or with chip select");
    sem_cs_high_a: assert property (($fell(PIN_CTRL.semaphore_select_n) && !PIN_CTRL.read_write_n)
        |-> PIN_CTRL.chip_select_n [*8])
        else $error("chip select low in semaphore sequence");
    answer_bound_a: assert property ((CMD_VALID && CMD_READY) |=> ##[0:48] RSP_VALID)
        else $error("answer later than retry bound");
endmodule : dpas_port_ctrl_asserts

// file: testbench/dpas_port_ctrl_bench.sv
// Purpose: Self-checking bench for the port controller against a memory port model.
// Assumes: 20 MHz clock; inputs change at the falling edge.
// Notes:   Latency is counted in cycles after the taking edge.
`timescale 1ns/1ps
module dpas_port_ctrl_bench;
    logic                     REF_CLK = 1'b0;
    logic                     ARST_N = 1'b0;
    logic                     CMD_VALID = 1'b0;
    dpas_pkg::dpas_cmd_t      CMD = '0;
    logic                     CMD_READY;
    logic                     RSP_VALID;
    dpas_pkg::dpas_rsp_t      RSP;
    dpas_pkg::dpas_pin_ctrl_t PIN_CTRL;
    logic [12:0]              PIN_ADDR;
    logic [15:0]              PIN_DATA_OUT;
    logic                     PIN_DATA_OE;
    logic [15:0]              PIN_DATA_IN;
    logic                     PIN_COLLISION_FLAG_N;
    logic [7:0]               other_req = 8'h00;
    logic                     other_busy = 1'b0;
    int                       errors = 0;
    int                       cmp_count = 0;
    int                       lat;
    initial forever #25 REF_CLK = ~REF_CLK;
    dpas_port_ctrl i_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CMD_VALID(CMD_VALID), .CMD(CMD),
        .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP(RSP), .PIN_CTRL(PIN_CTRL), .PIN_ADDR(PIN_ADDR),
        .PIN_DATA_OUT(PIN_DATA_OUT), .PIN_DATA_OE(PIN_DATA_OE), .PIN_DATA_IN(PIN_DATA_IN),
        .PIN_COLLISION_FLAG_N(PIN_COLLISION_FLAG_N));
    dpas_mem_model i_mem (.pins(PIN_CTRL), .addr(PIN_ADDR), .host_data(PIN_DATA_OUT), .host_oe(PIN_DATA_OE),
        .other_sem_req(other_req), .other_busy(other_busy), .other_addr(13'h0005), .data_pins(PIN_DATA_IN),
        .collision_flag_n(PIN_COLLISION_FLAG_N));
    task chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word
    task chk_bit(input logic got, input logic exp, input string what);
        chk_word({15'h0000, got}, {15'h0000, exp}, what);
    endtask : chk_bit
    // One command; returns at the falling edge where the answer pulse is seen
    task run(input logic [2:0] op, input logic [12:0] a, input logic [15:0] d, input logic ue, input logic le);
        @(negedge REF_CLK);
        CMD_VALID = 1'b1;
        CMD = {dpas_pkg::dpas_op_t'(op), a, d, ue, le};
        lat = -1;
        do
        begin
            @(negedge REF_CLK);
            CMD_VALID = 1'b0;
            lat++;
        end while (RSP_VALID !== 1'b1 && lat < 80);
        if (RSP_VALID !== 1'b1)
        begin
            errors++;
            $display("MISMATCH t=%0t no answer", $time);
        end
    endtask : run
    task t_ram;
        run(3'h1, 13'h0005, 16'hA5C3, 1'b1, 1'b1);
        chk_word(16'(lat), 16'h000A, "write latency");
        run(3'h0, 13'h0005, 16'h0000, 1'b1, 1'b1);
        chk_word(RSP.rdata, 16'hA5C3, "read data");
        chk_word(16'(lat), 16'h0009, "read latency");
        run(3'h1, 13'h0005, 16'h1234, 1'b1, 1'b0);
        run(3'h0, 13'h0005, 16'h0000, 1'b0, 1'b1);
        chk_word(RSP.rdata, 16'h12C3, "upper byte write");
        chk_bit(RSP.collided, 1'b0, "no collision");
        $display("test ram done");
    endtask : t_ram
    task t_sem;
        run(3'h2, 13'h0003, 16'h0000, 1'b1, 1'b1);
        chk_bit(RSP.granted, 1'b1, "take free latch");
        chk_word(16'(lat), 16'h000C, "take latency");
        run(3'h4, 13'h0003, 16'h0000, 1'b1, 1'b1);
        chk_bit(RSP.granted, 1'b1, "held latch read");
        run(3'h3, 13'h0003, 16'h0000, 1'b1, 1'b1);
        chk_bit(RSP.granted, 1'b0, "give latch");
        $display("test semaphore done");
    endtask : t_sem
    task t_contend;
        other_req[4] = 1'b1;
        run(3'h2, 13'h0004, 16'h0000, 1'b1, 1'b1);
        chk_bit(RSP.granted, 1'b0, "latch held by other");
        other_req[4] = 1'b0;
        run(3'h2, 13'h0004, 16'h0000, 1'b1, 1'b1);
        chk_bit(RSP.granted, 1'b1, "released latch claimed");
        run(3'h3, 13'h0004, 16'h0000, 1'b1, 1'b1);
        $display("test contention done");
    endtask : t_contend
    task t_collide;
        other_busy = 1'b1;
        run(3'h0, 13'h0005, 16'h0000, 1'b1, 1'b1);
        chk_bit(RSP.collided, 1'b1, "read flagged");
        chk_word(16'(lat), 16'h0030, "read retries");
        run(3'h1, 13'h0005, 16'h5A5A, 1'b1, 1'b1);
        chk_word(16'(lat), 16'h0025, "write retries");
        chk_bit(RSP.collided, 1'b1, "write flagged");
        run(3'h0, 13'h0006, 16'h0000, 1'b1, 1'b1);
        chk_bit(RSP.collided, 1'b0, "other address clear");
        other_busy = 1'b0;
        run(3'h5, 13'h0006, 16'h0000, 1'b1, 1'b1);
        chk_word(16'(lat), 16'h0002, "unknown op latency");
        chk_word(16'(PIN_CTRL), 16'(dpas_pkg::PINS_IDLE), "pins idle");
        $display("test collision done");
    endtask : t_collide
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    initial
    begin
        #100000;
        errors++;
        print_verdict();
    end
    initial
    begin
        repeat (10) @(negedge REF_CLK);
        ARST_N = 1'b1;
        chk_word(16'(PIN_CTRL), 16'(dpas_pkg::PINS_IDLE), "reset pins");
        chk_bit(CMD_READY, 1'b1, "ready after reset");
        t_ram();
        t_sem();
        t_contend();
        t_collide();
        print_verdict();
    end
endmodule : dpas_port_ctrl_bench
bind dpas_port_ctrl dpas_port_ctrl_asserts i_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .PIN_CTRL(PIN_CTRL), .PIN_ADDR(PIN_ADDR),
    .PIN_DATA_OE(PIN_DATA_OE));
